// [design/tlih_ctrl.sv]
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Source condition sets its pending flag
// - Request needs flag, source enable, global enable
// - After instruction completes, long call to vector
// - Return resumes the interrupted flow
// - Flags set even when source disabled
// - Chosen sources auto-clear flag on vectoring
// - Flag still set after return requests again
// - Every source has its own enable bit
// - Global enable sits in bit 7
// - Global enable low blocks every source
// - Flags raised while disabled stay pending
// - Software write of one acts as event
// - Per-source priority bit, low after reset
// - High preempts low, high never preempted
// - Preempted low routine resumes after high
// - Higher level first, then fixed order
// - Requests sampled and decoded every cycle
// - Best response seven clocks: 1+1+5
// - Equal or higher routine blocks until return
module tlih_ctrl #(
	parameter int unsigned NUM_SRC = tlih_pkg::NUM_SRC,
	parameter logic [31:0] AUTOCLR_MASK = tlih_pkg::AUTOCLR_MASK
)(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [NUM_SRC-1:0] src_event,
	input wire logic instr_done,
	input wire logic ret_done,
	output logic irq_req,
	output logic call_busy,
	output logic vector_valid,
	output logic [15:0] vector_addr,
	output logic srv_hi,
	output logic srv_lo
);
	localparam int unsigned IDXW = $clog2(NUM_SRC);
	localparam int unsigned BS = tlih_pkg::BASIC_SRC;

	logic [NUM_SRC-1:0] en_r;
	logic [NUM_SRC-1:0] prio_r;
	logic [NUM_SRC-1:0] pend_r;
	logic [NUM_SRC-1:0] pend_nxt;
	logic [NUM_SRC-1:0] eligible;
	logic [NUM_SRC-1:0] hi_elig;
	logic [NUM_SRC-1:0] hw_clr;
	logic gie_r;
	logic wr_en_r;
	logic rd_en_r;
	logic [2:0] sel_r;
	logic req_nxt;
	logic win_hi_nxt;
	logic [IDXW-1:0] win_idx_nxt;
	logic win_hi_r;
	logic [IDXW-1:0] win_idx_r;
	logic accept;
	logic [2:0] cnt_r;
	tlih_pkg::tlih_state_t state_r;
	logic wr_pend;

	function automatic logic [2:0] reg_sel(input logic [31:0] a);
		if (a[31:8] != 24'h000000 || a[1:0] != 2'h0)
			return tlih_pkg::SEL_NONE;
		case (a[7:0])
			tlih_pkg::OFS_ENA0: return tlih_pkg::SEL_ENA0;
			tlih_pkg::OFS_ENA1: return tlih_pkg::SEL_ENA1;
			tlih_pkg::OFS_PRI0: return tlih_pkg::SEL_PRI0;
			tlih_pkg::OFS_PRI1: return tlih_pkg::SEL_PRI1;
			tlih_pkg::OFS_PEND: return tlih_pkg::SEL_PEND;
			tlih_pkg::OFS_STAT: return tlih_pkg::SEL_STAT;
			default: return tlih_pkg::SEL_NONE;
		endcase
	endfunction

	// Lowest index wins within a level
	function automatic logic [IDXW-1:0] first_set(input logic [NUM_SRC-1:0] v);
		logic [IDXW-1:0] idx;
		idx = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
			if (v[i])
				idx = IDXW'(i);
		return idx;
	endfunction

	function automatic logic [15:0] vec_of(input logic [IDXW-1:0] idx);
		return 16'(tlih_pkg::VEC_BASE + tlih_pkg::VEC_STEP * 16'(idx));
	endfunction

	// Bus phases; reads take one wait state so a write just before is seen
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_en_r <= 1'b0;
			rd_en_r <= 1'b0;
			sel_r <= tlih_pkg::SEL_NONE;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else if (ce)
		begin
			if (hready && hsel && htrans == tlih_pkg::HTRANS_NONSEQ)
			begin
				wr_en_r <= hwrite;
				rd_en_r <= !hwrite;
				sel_r <= reg_sel(haddr);
				hreadyout <= hwrite;
			end
			else
			begin
				wr_en_r <= wr_en_r && !hreadyout;
				rd_en_r <= 1'b0;
				hreadyout <= 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (ce && rd_en_r)
		begin
			case (sel_r)
				tlih_pkg::SEL_ENA0: hrdata <= 32'({gie_r, en_r[BS-1:0]});
				tlih_pkg::SEL_ENA1: hrdata <= 32'(en_r[NUM_SRC-1:BS]);
				tlih_pkg::SEL_PRI0: hrdata <= 32'(prio_r[BS-1:0]);
				tlih_pkg::SEL_PRI1: hrdata <= 32'(prio_r[NUM_SRC-1:BS]);
				tlih_pkg::SEL_PEND: hrdata <= 32'(pend_r);
				tlih_pkg::SEL_STAT: hrdata <= 32'({win_idx_r, 5'h00,
					state_r == tlih_pkg::TLIH_CALL, srv_hi, srv_lo});
				default: hrdata <= 32'h00000000;
			endcase
		end
	end

	// Enables and priorities
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			gie_r <= 1'b0;
			en_r <= tlih_pkg::RST_ENABLE[NUM_SRC-1:0];
			prio_r <= tlih_pkg::RST_PRIO[NUM_SRC-1:0];
		end
		else if (ce && wr_en_r && hreadyout)
		begin
			case (sel_r)
				tlih_pkg::SEL_ENA0:
				begin
					gie_r <= hwdata[tlih_pkg::GIE_BIT];
					en_r[BS-1:0] <= hwdata[BS-1:0];
				end
				tlih_pkg::SEL_ENA1: en_r[NUM_SRC-1:BS] <= hwdata[NUM_SRC-BS-1:0];
				tlih_pkg::SEL_PRI0: prio_r[BS-1:0] <= hwdata[BS-1:0];
				tlih_pkg::SEL_PRI1: prio_r[NUM_SRC-1:BS] <= hwdata[NUM_SRC-BS-1:0];
				default: ;
			endcase
		end
	end

	// Pending flags: a hardware event beats a software clear in the same cycle
	assign wr_pend = wr_en_r && hreadyout && sel_r == tlih_pkg::SEL_PEND;

	generate
		for (genvar g = 0; g < NUM_SRC; g++)
		begin : g_pend
			assign hw_clr[g] = accept && AUTOCLR_MASK[g] && win_idx_r == IDXW'(g);
			assign pend_nxt[g] = ((wr_pend ? hwdata[g] : pend_r[g]) && !hw_clr[g])
				|| src_event[g];
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pend_r <= tlih_pkg::RST_PEND[NUM_SRC-1:0];
		else if (ce)
			pend_r <= pend_nxt;
	end

	// Decode every cycle; level already in service is shut out
	always_comb
	begin
		eligible = pend_r & en_r & {NUM_SRC{gie_r}};
		hi_elig = eligible & prio_r;
		req_nxt = 1'b0;
		win_hi_nxt = 1'b0;
		win_idx_nxt = '0;
		if (|hi_elig && !srv_hi)
		begin
			req_nxt = 1'b1;
			win_hi_nxt = 1'b1;
			win_idx_nxt = first_set(hi_elig);
		end
		else if (|eligible && !srv_hi && !srv_lo)
		begin
			req_nxt = 1'b1;
			win_idx_nxt = first_set(eligible);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_req <= 1'b0;
			win_hi_r <= 1'b0;
			win_idx_r <= '0;
		end
		else if (ce)
		begin
			irq_req <= req_nxt;
			win_hi_r <= win_hi_nxt;
			win_idx_r <= win_idx_nxt;
		end
	end

	// The instruction that retires with a return never starts a call; the registered
	// winner is rechecked so a flag or enable dropped a cycle ago cannot vector
	assign accept = ce && irq_req && instr_done && !ret_done && eligible[win_idx_r]
		&& state_r == tlih_pkg::TLIH_IDLE;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r <= tlih_pkg::TLIH_IDLE;
			cnt_r <= 3'h0;
			call_busy <= 1'b0;
			vector_valid <= 1'b0;
			vector_addr <= 16'h0000;
		end
		else if (ce)
		begin
			vector_valid <= 1'b0;
			case (state_r)
				tlih_pkg::TLIH_IDLE:
					if (accept)
					begin
						state_r <= tlih_pkg::TLIH_CALL;
						cnt_r <= tlih_pkg::CALL_CNT_INIT;
						call_busy <= 1'b1;
						vector_addr <= vec_of(win_idx_r);
					end
				tlih_pkg::TLIH_CALL:
					if (cnt_r == 3'h0)
					begin
						state_r <= tlih_pkg::TLIH_IDLE;
						call_busy <= 1'b0;
						vector_valid <= 1'b1;
					end
					else
						cnt_r <= cnt_r - 3'h1;
				default: state_r <= tlih_pkg::TLIH_IDLE;
			endcase
		end
	end

	// Two-deep service record; return pops the highest level
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			srv_hi <= 1'b0;
			srv_lo <= 1'b0;
		end
		else if (ce)
		begin
			if (accept && win_hi_r)
				srv_hi <= 1'b1;
			else if (accept)
				srv_lo <= 1'b1;
			else if (ret_done && srv_hi)
				srv_hi <= 1'b0;
			else if (ret_done)
				srv_lo <= 1'b0;
		end
	end

	a_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && src_event[0] |=> pend_r[0])
		else $error("event did not set its pending flag");
	a_gie_block: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && $past(ce) && !gie_r && !$past(gie_r) |-> !irq_req)
		else $error("request raised with global enable low");
	a_req_cause: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && $past(ce) && irq_req |-> ($past(pend_r) & $past(en_r)) != '0 && $past(gie_r))
		else $error("request without an enabled pending flag");
	a_call_len: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		accept |=> call_busy [*5] ##1 (vector_valid && !call_busy))
		else $error("long call length wrong");
	a_hi_no_preempt: assert property (@(posedge hclk) disable iff (!hresetn)
		srv_hi |-> !accept)
		else $error("high routine preempted");
	a_lo_blocks_lo: assert property (@(posedge hclk) disable iff (!hresetn)
		accept && srv_lo |-> win_hi_r)
		else $error("equal level preempted low routine");
	a_return_gap: assert property (@(posedge hclk) disable iff (!hresetn)
		ret_done |-> !accept)
		else $error("call started on the return itself");
	a_retake_req: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		$fell(srv_lo) && !srv_hi && gie_r && (pend_r & en_r) != '0 |=> irq_req)
		else $error("flag still set after return raised no request");
	a_vec_map: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		accept |=> vector_addr == 16'(tlih_pkg::VEC_BASE
			+ tlih_pkg::VEC_STEP * 16'($past(win_idx_r))))
		else $error("vector address mismatch");
	a_pend_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && pend_r[NUM_SRC-1] && !gie_r && !wr_pend |=> pend_r[NUM_SRC-1])
		else $error("pending flag lost while disabled");
	a_auto_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		accept && AUTOCLR_MASK[win_idx_r] && !src_event[win_idx_r] && !wr_pend
			|=> !pend_r[$past(win_idx_r)])
		else $error("auto-clear flag not cleared");
	a_hi_first: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && $past(ce) && irq_req && !win_hi_r |-> $past(hi_elig) == '0 || $past(srv_hi))
		else $error("low level won over high");

	c_call: cover property (@(posedge hclk) disable iff (!hresetn) accept ##6 vector_valid);
	c_preempt: cover property (@(posedge hclk) disable iff (!hresetn) srv_lo && accept);
	c_nested: cover property (@(posedge hclk) disable iff (!hresetn) srv_hi && srv_lo);
	c_retake: cover property (@(posedge hclk) disable iff (!hresetn)
		ret_done ##[1:20] accept);
	c_gie_late: cover property (@(posedge hclk) disable iff (!hresetn)
		!gie_r && pend_r != '0 ##1 gie_r);
endmodule // tlih_ctrl
`default_nettype wire

// [dv/tlih_core_model.sv]
`timescale 1ns/100ps
`default_nettype none
module tlih_core_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic instr_en,
	input wire logic ret_req,
	input wire logic call_busy,
	input wire logic srv_hi,
	input wire logic srv_lo,
	output logic instr_done,
	output logic ret_done
);
	// One-cycle instructions; fetch stalls while the long call pushes the return
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			instr_done <= 1'b0;
			ret_done <= 1'b0;
		end
		else
		begin
			instr_done <= instr_en && !call_busy;
			ret_done <= ret_req && (srv_hi || srv_lo) && !call_busy;
		end
	end
endmodule // tlih_core_model
`default_nettype wire

// [dv/two_level_interrupt_handler_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module two_level_interrupt_handler_tb_top;
	logic hclk;
	logic hresetn;
	logic hsel, hwrite, instr_en, ret_req, hreadyout, hresp;
	logic irq_req, call_busy, vector_valid, srv_hi, srv_lo, instr_done, ret_done;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [15:0] vector_addr;
	logic [tlih_pkg::NUM_SRC-1:0] src_event;
	int errors, n_tests, n;
	int cyc = 0;

	tlih_ctrl dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_event(src_event),
		.instr_done(instr_done), .ret_done(ret_done), .irq_req(irq_req),
		.call_busy(call_busy), .vector_valid(vector_valid), .vector_addr(vector_addr),
		.srv_hi(srv_hi), .srv_lo(srv_lo));

	tlih_core_model core (.hclk(hclk), .hresetn(hresetn), .instr_en(instr_en),
		.ret_req(ret_req), .call_busy(call_busy), .srv_hi(srv_hi), .srv_lo(srv_lo),
		.instr_done(instr_done), .ret_done(ret_done));

	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	task automatic summarize;
		if (errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Generous ceiling: the whole sequence needs well under a thousand cycles
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			summarize();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= tlih_pkg::HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk(nm, e, q);
		chk("hresp", 32'h0, 32'(hresp));
	endtask

	task automatic fire(input int i);
		@(posedge hclk);
		src_event[i] <= 1'b1;
		@(posedge hclk);
		src_event <= '0;
	endtask

	task automatic vec(input logic [15:0] e);
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (vector_valid !== 1'b1 && n < 60);
		chk("vector_valid", 32'h1, 32'(vector_valid));
		chk("vector_addr", 32'(e), 32'(vector_addr));
	endtask

	task automatic nov;
		logic seen;
		seen = 1'b0;
		repeat (20)
		begin
			@(posedge hclk);
			seen |= vector_valid;
		end
		chk("no vector", 32'h0, 32'(seen));
	endtask

	// Instructions pause around the return so it never meets a starting call
	task automatic leave_routine;
		instr_en <= 1'b0;
		@(posedge hclk);
		ret_req <= 1'b1;
		@(posedge hclk);
		ret_req <= 1'b0;
		instr_en <= 1'b1;
		repeat (2) @(posedge hclk);
	endtask

	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b1;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		src_event = '0;
		instr_en = 1'b0;
		ret_req = 1'b0;
		errors = 0;
		n_tests = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		instr_en <= 1'b1;
		for (int i = 0; i < 6; i++) rdc("reset value", 8'(4 * i), 32'h0);
		wr(8'h18, 32'hffffffff);
		rdc("unmapped", 8'h18, 32'h0);
		wr(tlih_pkg::OFS_ENA0, 32'h08);
		fire(3);
		nov();
		chk("irq_req", 32'h0, 32'(irq_req));
		rdc("pend held", tlih_pkg::OFS_PEND, 32'h08);
		wr(tlih_pkg::OFS_ENA0, 32'h88);
		vec(16'h001b);
		rdc("auto clear", tlih_pkg::OFS_PEND, 32'h0);
		leave_routine();
		fire(3);
		vec(16'h001b);
		chk("latency", 32'(tlih_pkg::RESPONSE_CYC + 1), 32'(n));
		leave_routine();
		wr(tlih_pkg::OFS_ENA0, 32'he4);
		wr(tlih_pkg::OFS_PEND, 32'h20);
		vec(16'h002b);
		rdc("sticky pend", tlih_pkg::OFS_PEND, 32'h20);
		nov();
		leave_routine();
		vec(16'h002b);
		wr(tlih_pkg::OFS_PEND, 32'h0);
		leave_routine();
		wr(tlih_pkg::OFS_PEND, 32'h44);
		vec(16'h0013);
		leave_routine();
		vec(16'h0033);
		wr(tlih_pkg::OFS_PEND, 32'h0);
		leave_routine();
		wr(tlih_pkg::OFS_PRI0, 32'h40);
		wr(tlih_pkg::OFS_PEND, 32'h44);
		vec(16'h0033);
		nov();
		wr(tlih_pkg::OFS_PEND, 32'h04);
		leave_routine();
		vec(16'h0013);
		leave_routine();
		wr(tlih_pkg::OFS_PEND, 32'h20);
		vec(16'h002b);
		fire(6);
		vec(16'h0033);
		chk("nested", 32'h3, {30'h0, srv_hi, srv_lo});
		rdc("status nested", tlih_pkg::OFS_STAT, 32'h3);
		wr(tlih_pkg::OFS_PEND, 32'h0);
		leave_routine();
		chk("resumed", 32'h1, {30'h0, srv_hi, srv_lo});
		leave_routine();
		wr(tlih_pkg::OFS_ENA1, 32'h800);
		fire(18);
		vec(16'h0093);
		leave_routine();
		summarize();
	end
endmodule // two_level_interrupt_handler_tb_top
`default_nettype wire

// [pkg/tlih_pkg.sv]
package tlih_pkg;
	localparam int unsigned NUM_SRC = 19;
	localparam int unsigned BASIC_SRC = 7;
	localparam int unsigned GIE_BIT = 7;
	localparam logic [7:0] OFS_ENA0 = 8'h00;
	localparam logic [7:0] OFS_ENA1 = 8'h04;
	localparam logic [7:0] OFS_PRI0 = 8'h08;
	localparam logic [7:0] OFS_PRI1 = 8'h0c;
	localparam logic [7:0] OFS_PEND = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;
	localparam logic [2:0] SEL_ENA0 = 3'h0;
	localparam logic [2:0] SEL_ENA1 = 3'h1;
	localparam logic [2:0] SEL_PRI0 = 3'h2;
	localparam logic [2:0] SEL_PRI1 = 3'h3;
	localparam logic [2:0] SEL_PEND = 3'h4;
	localparam logic [2:0] SEL_STAT = 3'h5;
	localparam logic [2:0] SEL_NONE = 3'h7;
	localparam logic [31:0] RST_ENABLE = 32'h00000000;
	localparam logic [31:0] RST_PRIO = 32'h00000000;
	localparam logic [31:0] RST_PEND = 32'h00000000;
	localparam logic [31:0] AUTOCLR_MASK = 32'h0000000f;
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam logic [15:0] VEC_STEP = 16'h0008;
	localparam int unsigned DETECT_CYC = 1;
	localparam int unsigned INSTR_CYC = 1;
	localparam int unsigned CALL_CYC = 5;
	localparam int unsigned RESPONSE_CYC = DETECT_CYC + INSTR_CYC + CALL_CYC;
	localparam logic [2:0] CALL_CNT_INIT = 3'(CALL_CYC - 1);
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef enum logic {TLIH_IDLE, TLIH_CALL} tlih_state_t;
endpackage
